// ---- verilog/tmc_defines.vh ----
// Constants for the 8/16-bit timer/counter core: register map, fields, codes.
// Assumes a classic Wishbone slave with 32-bit data, byte addressed, one word per register.
// Overview of operation
// - Counter low byte, compare A, B are 8-bit
// - 16-bit mode adds counter high byte
// - 16-bit compare: A low, B high
// - 8-bit mode: two independent compare units
// - Four interrupt sources: overflow, A, B, capture
// - Flags shared register, each individually maskable
// - Counter zero is bottom
// - All ones is maximum
// - Top is maximum or compare A (B:A in 16-bit mode)
// - Three-bit clock select; zero stops counter
// - Select one counts every system clock
// - Four prescaler taps selectable
// - External count pin as clock source
// - Clear counter on compare match mode
// - Taps divide by 8, 64, 256, 1024
// - Select 6 falling edge, 7 rising edge
// - CPU counter write beats clear or count
// - Overflow flag set on reaching maximum
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH

`define TMC_ADR_CNT_LO   8'h00
`define TMC_ADR_CNT_HI   8'h04
`define TMC_ADR_CMP_A    8'h08
`define TMC_ADR_CMP_B    8'h0C
`define TMC_ADR_CTRL_A   8'h10
`define TMC_ADR_CTRL_B   8'h14
`define TMC_ADR_FLAG     8'h18
`define TMC_ADR_MASK     8'h1C

// Control A fields
`define TMC_CA_WIDE      0
`define TMC_CA_CTC       1
// Flag and mask bit positions
`define TMC_F_OVF        0
`define TMC_F_CMPA       1
`define TMC_F_CMPB       2
`define TMC_F_CAPT       3

`define TMC_CS_STOP      3'h0
`define TMC_CS_SYS       3'h1
`define TMC_CS_DIV8      3'h2
`define TMC_CS_DIV64     3'h3
`define TMC_CS_DIV256    3'h4
`define TMC_CS_DIV1024   3'h5
`define TMC_CS_EXT_FALL  3'h6
`define TMC_CS_EXT_RISE  3'h7

`define TMC_BOTTOM       16'h0000
`define TMC_MAX8         8'hFF
`define TMC_MAX16        16'hFFFF
`define TMC_PRE_W        10

`endif

// ---- verilog/tmc_prescaler.v ----
// Free-running prescaler producing one-cycle ticks at the four divide taps.
// Assumes a single system clock, synchronous reset and a global clock enable.
`include "tmc_defines.vh"
module tmc_prescaler
#(
    parameter W = `TMC_PRE_W
)
(
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       ce_i,
    output reg        tick8_o,
    output reg        tick64_o,
    output reg        tick256_o,
    output reg        tick1024_o
);
    reg  [W-1:0] cnt_r;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_r      <= {W{1'b0}};
            tick8_o    <= 1'b0;
            tick64_o   <= 1'b0;
            tick256_o  <= 1'b0;
            tick1024_o <= 1'b0;
        end
        else if (ce_i)
        begin
            cnt_r      <= cnt_r + {{(W-1){1'b0}}, 1'b1};
            tick8_o    <= &cnt_r[2:0];
            tick64_o   <= &cnt_r[5:0];
            tick256_o  <= &cnt_r[7:0];
            tick1024_o <= &cnt_r[9:0];
        end
    end
endmodule

// ---- verilog/tmc_timer.v ----
// Timer/counter core top: Wishbone register file, clock select, counter, compares.
// Assumes ext_count_pin_i and capture_evt_i are synchronous to clk_i.
`include "tmc_defines.vh"
module tmc_timer
(
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        ce_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        ext_count_pin_i,
    input  wire        capture_evt_i,
    output reg  [3:0]  irq_o
);
    reg  [7:0]  counter_low_byte_r;
    reg  [7:0]  counter_high_byte_r;
    reg  [7:0]  compare_reg_a_r;
    reg  [7:0]  compare_reg_b_r;
    reg  [1:0]  ctrl_a_r;
    reg  [2:0]  clock_select_field_r;
    reg  [3:0]  timer_flag_register_r;
    reg  [3:0]  timer_mask_register_r;
    reg         pin_s1_r;
    reg         pin_s2_r;
    reg         pin_prev_r;
    reg         selected_timer_clock;
    reg  [15:0] cnt_nxt;
    reg  [3:0]  set_v;
    wire        t8;
    wire        t64;
    wire        t256;
    wire        t1024;
    wire        wide;
    wire        ctc;
    wire [15:0] cnt;
    wire [15:0] cmp16;
    wire [15:0] top;
    wire        at_top;
    wire        hit_a;
    wire        hit_b;
    wire        req;
    wire        wr;
    wire        wr_lo;
    wire        wr_hi;

    function wr_sel;
        input [7:0] adr;
        input [7:0] target;
        begin
            wr_sel = (adr == target);
        end
    endfunction

    tmc_prescaler #(.W(`TMC_PRE_W)) u_pre
    (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .tick8_o    (t8),
        .tick64_o   (t64),
        .tick256_o  (t256),
        .tick1024_o (t1024)
    );

    assign wide   = ctrl_a_r[`TMC_CA_WIDE];
    assign ctc    = ctrl_a_r[`TMC_CA_CTC];
    assign cnt    = wide ? {counter_high_byte_r, counter_low_byte_r}
                         : {8'h00, counter_low_byte_r};
    assign cmp16  = wide ? {compare_reg_b_r, compare_reg_a_r}
                         : {8'h00, compare_reg_a_r};
    assign top    = ctc ? cmp16 : (wide ? `TMC_MAX16 : {8'h00, `TMC_MAX8});
    assign at_top = (cnt == top);
    assign hit_a  = (cnt == cmp16);
    assign hit_b  = !wide && (counter_low_byte_r == compare_reg_b_r);
    assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr     = req && wb_we_i && wb_sel_i[0];
    assign wr_lo  = wr && wr_sel(wb_adr_i, `TMC_ADR_CNT_LO);
    assign wr_hi  = wr && wr_sel(wb_adr_i, `TMC_ADR_CNT_HI);

    // Clock select: choose one-cycle count strobe
    always @*
    begin
        case (clock_select_field_r)
            `TMC_CS_STOP:     selected_timer_clock = 1'b0;
            `TMC_CS_SYS:      selected_timer_clock = 1'b1;
            `TMC_CS_DIV8:     selected_timer_clock = t8;
            `TMC_CS_DIV64:    selected_timer_clock = t64;
            `TMC_CS_DIV256:   selected_timer_clock = t256;
            `TMC_CS_DIV1024:  selected_timer_clock = t1024;
            `TMC_CS_EXT_FALL: selected_timer_clock = pin_prev_r && !pin_s2_r;
            `TMC_CS_EXT_RISE: selected_timer_clock = !pin_prev_r && pin_s2_r;
            default:          selected_timer_clock = 1'b0;
        endcase
    end

    // Counter next value and flag events
    always @*
    begin
        cnt_nxt = cnt;
        set_v   = 4'h0;
        if (selected_timer_clock)
        begin
            if (ctc && at_top)
                cnt_nxt = `TMC_BOTTOM;
            else
                cnt_nxt = cnt + 16'h0001;
            if (!wide)
                cnt_nxt = {8'h00, cnt_nxt[7:0]};
            set_v[`TMC_F_OVF]  = (cnt_nxt == (wide ? `TMC_MAX16
                                             : {8'h00, `TMC_MAX8}));
            set_v[`TMC_F_CMPA] = hit_a;
            set_v[`TMC_F_CMPB] = hit_b;
        end
        set_v[`TMC_F_CAPT] = capture_evt_i;
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            counter_low_byte_r    <= 8'h00;
            counter_high_byte_r   <= 8'h00;
            compare_reg_a_r       <= 8'h00;
            compare_reg_b_r       <= 8'h00;
            ctrl_a_r              <= 2'h0;
            clock_select_field_r  <= `TMC_CS_STOP;
            timer_flag_register_r <= 4'h0;
            timer_mask_register_r <= 4'h0;
            pin_s1_r              <= 1'b0;
            pin_s2_r              <= 1'b0;
            pin_prev_r            <= 1'b0;
            wb_ack_o              <= 1'b0;
            wb_dat_o              <= 32'h0000_0000;
            irq_o                 <= 4'h0;
        end
        else if (ce_i)
        begin
            pin_s1_r   <= ext_count_pin_i;
            pin_s2_r   <= pin_s1_r;
            pin_prev_r <= pin_s2_r;
            wb_ack_o   <= req;
            // Counter: CPU write overrides count and clear
            counter_low_byte_r  <= wr_lo ? wb_dat_i[7:0] : cnt_nxt[7:0];
            counter_high_byte_r <= wr_hi ? wb_dat_i[7:0] : cnt_nxt[15:8];
            if (wr && wr_sel(wb_adr_i, `TMC_ADR_CMP_A))
                compare_reg_a_r <= wb_dat_i[7:0];
            if (wr && wr_sel(wb_adr_i, `TMC_ADR_CMP_B))
                compare_reg_b_r <= wb_dat_i[7:0];
            if (wr && wr_sel(wb_adr_i, `TMC_ADR_CTRL_A))
                ctrl_a_r <= wb_dat_i[1:0];
            if (wr && wr_sel(wb_adr_i, `TMC_ADR_CTRL_B))
                clock_select_field_r <= wb_dat_i[2:0];
            if (wr && wr_sel(wb_adr_i, `TMC_ADR_MASK))
                timer_mask_register_r <= wb_dat_i[3:0];
            // Write one to clear; a simultaneous event keeps its flag
            if (wr && wr_sel(wb_adr_i, `TMC_ADR_FLAG))
                timer_flag_register_r <= (timer_flag_register_r & ~wb_dat_i[3:0]) | set_v;
            else
                timer_flag_register_r <= timer_flag_register_r | set_v;
            irq_o <= timer_flag_register_r & timer_mask_register_r;
            if (req && !wb_we_i)
            begin
                case (wb_adr_i)
                    `TMC_ADR_CNT_LO: wb_dat_o <= {24'h000000, counter_low_byte_r};
                    `TMC_ADR_CNT_HI: wb_dat_o <= {24'h000000, counter_high_byte_r};
                    `TMC_ADR_CMP_A:  wb_dat_o <= {24'h000000, compare_reg_a_r};
                    `TMC_ADR_CMP_B:  wb_dat_o <= {24'h000000, compare_reg_b_r};
                    `TMC_ADR_CTRL_A: wb_dat_o <= {30'h0, ctrl_a_r};
                    `TMC_ADR_CTRL_B: wb_dat_o <= {29'h0, clock_select_field_r};
                    `TMC_ADR_FLAG:   wb_dat_o <= {28'h0000000, timer_flag_register_r};
                    `TMC_ADR_MASK:   wb_dat_o <= {28'h0000000, timer_mask_register_r};
                    default:         wb_dat_o <= 32'h0000_0000;
                endcase
            end
            else
                wb_dat_o <= 32'h0000_0000;
        end
    end
endmodule

// ---- tb/tmc_timer_chk.sv ----
// Checker for the timer core bus and interrupt ports.
// Assumes binding to tmc_timer; the bind follows the module.
`include "tmc_defines.vh"
module tmc_chk
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        ext_count_pin_i,
    input wire logic        capture_evt_i,
    input wire logic [3:0]  irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] msk_r;
    wire        take = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
    // Shadow of the mask register
    always @(posedge clk_i)
    begin
        if (rst_i)
            msk_r <= 4'h0;
        else if (take & wb_we_i & wb_sel_i[0] & (wb_adr_i == `TMC_ADR_MASK))
            msk_r <= wb_dat_i[3:0];
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_ack; take |=> wb_ack_o; endproperty
    property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_spur; !take |=> !wb_ack_o; endproperty
    property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    property p_byte; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
    property p_unmap; take && !wb_we_i && wb_adr_i > 8'h1C |=> wb_dat_o == 32'h0; endproperty
    property p_mask; (irq_o & ~msk_r & ~$past(msk_r)) == 4'h0; endproperty
    property p_capt; capture_evt_i && msk_r[3] |=> ##1 irq_o[3]; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    a_pulse: assert property (p_pulse) else $error("ack too long");
    a_spur: assert property (p_spur) else $error("ack without request");
    a_idle: assert property (p_idle) else $error("read data outside ack");
    a_byte: assert property (p_byte) else $error("read wider than a byte");
    a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
    a_mask: assert property (p_mask) else $error("masked request seen");
    a_capt: assert property (p_capt) else $error("capture request missing");
    c_capt: cover property (capture_evt_i && msk_r[3]);
    c_ovf: cover property (irq_o[0]);
    c_cmpa: cover property (irq_o[1]);
endmodule
bind tmc_timer tmc_chk chk_u
(
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_count_pin_i(ext_count_pin_i),
    .capture_evt_i(capture_evt_i), .irq_o(irq_o)
);

// ---- tb/tmc_timer_tb.sv ----
// Self-checking bench for the timer core over Wishbone.
// Assumes tmc_timer with its checker bound, clocked at 250 MHz.
`include "tmc_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        req = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic        pin = 1'b0;
    logic        evt = 1'b0;
    logic        ce = 1'b1;
    logic [3:0]  sel = 4'hF;
    logic [31:0] rdat;
    logic        ack;
    logic [3:0]  irq;
    logic [31:0] rd;
    integer      failures = 0;
    integer      tests_run = 0;
    tmc_timer dut_u
    (
        .clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .ext_count_pin_i(pin),
        .capture_evt_i(evt), .irq_o(irq)
    );
    initial
    begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // One classic cycle; holds the request until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        we <= w;
        adr <= a;
        wdat <= d;
        req <= 1'b1;
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        rd = rdat;
        req <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic t_reset;
        rc(`TMC_ADR_CTRL_B, 32'h0);
        wr(`TMC_ADR_CNT_LO, 32'hA5);
        wr(`TMC_ADR_CMP_A, 32'h3C);
        wr(`TMC_ADR_CMP_B, 32'hC3);
        wr(8'h20, 32'h5A);
        rc(`TMC_ADR_CNT_LO, 32'hA5);
        rc(`TMC_ADR_CMP_A, 32'h3C);
        rc(`TMC_ADR_CMP_B, 32'hC3);
        rc(8'h20, 32'h0);
    endtask
    task automatic t_taps;
        integer i;
        integer dv;
        for (i = 0; i < 5; i = i + 1)
        begin
            dv = 1 << ((i < 3) ? 3 * i : 2 * i + 2);
            wr(`TMC_ADR_CTRL_B, 32'h0);
            wr(`TMC_ADR_CNT_LO, 32'h0);
            wr(`TMC_ADR_CTRL_B, i + 1);
            repeat (10 * dv) @(posedge clk);
            wb(1'b0, `TMC_ADR_CNT_LO, 32'h0);
            chk(rd >= 9 && rd <= (dv == 1 ? 14 : 11), 1'b1);
        end
    endtask
    task automatic t_ext;
        integer k;
        for (k = 0; k < 2; k = k + 1)
        begin
            wr(`TMC_ADR_CTRL_B, 32'h0);
            wr(`TMC_ADR_CNT_LO, 32'h0);
            wr(`TMC_ADR_CTRL_B, 6 + k);
            repeat (5)
            begin
                pin <= 1'b1;
                repeat (3) @(posedge clk);
                pin <= 1'b0;
                repeat (3) @(posedge clk);
            end
            repeat (4) @(posedge clk);
            rc(`TMC_ADR_CNT_LO, 32'h5);
        end
    endtask
    task automatic t_ctc;
        wr(`TMC_ADR_CTRL_B, 32'h0);
        wr(`TMC_ADR_CNT_LO, 32'h0);
        wr(`TMC_ADR_CMP_A, 32'h5);
        wr(`TMC_ADR_CMP_B, 32'h2);
        wr(`TMC_ADR_CTRL_A, 32'h2);
        wr(`TMC_ADR_MASK, 32'h6);
        wr(`TMC_ADR_CTRL_B, 32'h1);
        repeat (20)
        begin
            wb(1'b0, `TMC_ADR_CNT_LO, 32'h0);
            chk(rd <= 5, 1'b1);
        end
        chk(irq, 32'h6);
        wr(`TMC_ADR_CTRL_B, 32'h0);
        wr(`TMC_ADR_FLAG, 32'hF);
    endtask
    task automatic t_wide;
        wr(`TMC_ADR_CTRL_A, 32'h1);
        wr(`TMC_ADR_CNT_HI, 32'h12);
        rc(`TMC_ADR_CNT_HI, 32'h12);
        wr(`TMC_ADR_CNT_HI, 32'hFF);
        wr(`TMC_ADR_CNT_LO, 32'hF0);
        wr(`TMC_ADR_MASK, 32'h1);
        wr(`TMC_ADR_CTRL_B, 32'h1);
        chk(irq, 32'h0);
        repeat (20) @(posedge clk);
        chk(irq, 32'h1);
        wr(`TMC_ADR_CNT_LO, 32'h40);
        wr(`TMC_ADR_CTRL_B, 32'h0);
        wb(1'b0, `TMC_ADR_CNT_LO, 32'h0);
        chk(rd >= 32'h40 && rd <= 32'h44, 1'b1);
        rc(`TMC_ADR_CNT_HI, 32'h0);
        wr(`TMC_ADR_FLAG, 32'h1);
        chk(irq, 32'h0);
        wr(`TMC_ADR_CNT_LO, 32'h0);
        wr(`TMC_ADR_CMP_A, 32'h2);
        wr(`TMC_ADR_CMP_B, 32'h1);
        wr(`TMC_ADR_CTRL_A, 32'h3);
        wr(`TMC_ADR_MASK, 32'h2);
        wr(`TMC_ADR_CTRL_B, 32'h1);
        repeat (100) @(posedge clk);
        chk(irq, 32'h0);
        repeat (200) @(posedge clk);
        chk(irq, 32'h2);
        wr(`TMC_ADR_CTRL_B, 32'h0);
        wr(`TMC_ADR_FLAG, 32'hF);
    endtask
    task automatic t_capt;
        wr(`TMC_ADR_MASK, 32'h0);
        evt <= 1'b1;
        @(posedge clk);
        evt <= 1'b0;
        repeat (3) @(posedge clk);
        chk(irq, 32'h0);
        wr(`TMC_ADR_MASK, 32'h8);
        chk(irq, 32'h8);
        wr(`TMC_ADR_FLAG, 32'h8);
        chk(irq, 32'h0);
        evt <= 1'b1;
        @(posedge clk);
        evt <= 1'b0;
        repeat (3) @(posedge clk);
        chk(irq, 32'h8);
    endtask
    // Byte lane 0 gates writes; a low clock enable freezes the counter
    task automatic t_misc;
        sel <= 4'hE;
        wr(`TMC_ADR_CMP_A, 32'h77);
        sel <= 4'hF;
        rc(`TMC_ADR_CMP_A, 32'h2);
        wr(`TMC_ADR_CTRL_A, 32'h0);
        wr(`TMC_ADR_CNT_LO, 32'h0);
        wr(`TMC_ADR_CTRL_B, 32'h1);
        ce <= 1'b0;
        repeat (50) @(posedge clk);
        ce <= 1'b1;
        wb(1'b0, `TMC_ADR_CNT_LO, 32'h0);
        chk(rd >= 1 && rd <= 4, 1'b1);
        wr(`TMC_ADR_CTRL_B, 32'h0);
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_taps;
        t_ext;
        t_ctc;
        t_wide;
        t_capt;
        t_misc;
        finish_test;
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        failures = failures + 1;
        finish_test;
    end
endmodule
